// [rtl/burst_sram_regs.vh]
// Constants of the two-word burst SRAM port: widths and read latencies.
// Assumes it is included by bare name from the port and array files.
// Function
// - Host gives read and write addresses on alternate true-clock rises; device latches each.
// - Write data is taken on true-clock rise and on complementary-clock rise.
// - Read data is launched on both clock rises, one word per rise.
// - Each address holds two words bursting in order; word width 18 or 36.
// - Bypass select high: read data 2.5 cycles after address latch.
// - Bypass select low: read data one cycle after address latch.
// - Valid flag is high while driven read words are valid.
// - Echo strobe pair is driven in step with read data.
// - Every synchronous input is registered on a link clock rise.
// - Every data output leaves from registers on a link clock rise.
// - Array writes are self-timed; no write strobe beyond synchronous inputs.
// - Data pins are shared; device drives them only while returning read data.
// - 72 Mbit as 4M x 18 or 2M x 36; address width follows.
// - Only rising edges of both link clocks are used.
`ifndef BURST_SRAM_REGS_VH
`define BURST_SRAM_REGS_VH
`define BSR_WORD_W 18
`define BSR_ADDR_W 21
`define BSR_LAT_PLL_HALF 5
`define BSR_LAT_BYP_HALF 2
`define BSR_PIPE_DEPTH 5
`endif

// [rtl/burst_sram_array.v]
// Storage array holding one two-word burst per address.
// Assumes one access per cycle; read data appear one cycle later from a register.
`timescale 1ns/1ps
`default_nettype none
`include "burst_sram_regs.vh"
module burst_sram_array #(
	parameter ADDR_W = `BSR_ADDR_W,
	parameter DATA_W = 2 * `BSR_WORD_W
) (
	input wire clk,
	input wire ce,
	input wire wr_en,
	input wire rd_en,
	input wire [ADDR_W-1:0] addr,
	input wire [DATA_W-1:0] wr_data,
	output reg [DATA_W-1:0] rd_data_q
);
	reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Write has priority; the port never asks for both in one cycle
	always @(posedge clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[addr] <= wr_data;
			end else if (rd_en) begin
				rd_data_q <= mem[addr];
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/dual_rate_burst_sram_port.v]
// Device side of a two-word burst, double-rate SRAM port with echo strobes.
// Assumes the link clocks and all pins are asynchronous to clk and much slower.
`timescale 1ns/1ps
`default_nettype none
`include "burst_sram_regs.vh"
module dual_rate_burst_sram_port #(
	parameter WORD_W = `BSR_WORD_W,
	parameter ADDR_W = `BSR_ADDR_W
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire link_clk_true,
	input wire link_clk_comp,
	input wire load_n,
	input wire read_not_write,
	input wire [ADDR_W-1:0] addr,
	input wire pll_bypass_select,
	input wire [WORD_W-1:0] dq_in,
	output reg [WORD_W-1:0] dq_out,
	output reg dq_oe_n,
	output reg read_valid_flag,
	output reg echo_strobe_true,
	output reg echo_strobe_comp
);
	localparam DEPTH = `BSR_PIPE_DEPTH;
	localparam LAT_PLL = `BSR_LAT_PLL_HALF;
	localparam LAT_BYP = `BSR_LAT_BYP_HALF;
	localparam SYNC_W = 4 + ADDR_W + WORD_W;

	// Two-flop synchronisers for every pin; only stage two is read
	reg [SYNC_W-1:0] sync1_q;
	reg [SYNC_W-1:0] sync2_q;
	reg kt_prev_q;
	reg kc_prev_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= {SYNC_W{1'b0}};
			sync2_q <= {SYNC_W{1'b0}};
			kt_prev_q <= 1'b0;
			kc_prev_q <= 1'b0;
		end else if (ce) begin
			sync1_q <= {link_clk_true, link_clk_comp, ~load_n, read_not_write, addr, dq_in};
			sync2_q <= sync1_q;
			kt_prev_q <= sync2_q[SYNC_W-1];
			kc_prev_q <= sync2_q[SYNC_W-2];
		end
	end

	wire kt_s = sync2_q[SYNC_W-1];
	wire kc_s = sync2_q[SYNC_W-2];
	wire load_s = sync2_q[SYNC_W-3];
	wire rd_s = sync2_q[SYNC_W-4];
	wire [ADDR_W-1:0] addr_s = sync2_q[ADDR_W+WORD_W-1:WORD_W];
	wire [WORD_W-1:0] din_s = sync2_q[WORD_W-1:0];

	// Rising edges only; falling edges carry no meaning
	wire kt_rise = ce & kt_s & ~kt_prev_q;
	wire kc_rise = ce & kc_s & ~kc_prev_q;
	wire any_rise = kt_rise | kc_rise;

	// Commands are taken only on the true clock rise
	wire rd_cmd = kt_rise & load_s & rd_s;
	wire wr_cmd = kt_rise & load_s & ~rd_s;

	// Write path: address now, low word next true rise, high word on comp rise
	reg wq_valid_q;
	reg [ADDR_W-1:0] wq_addr_q;
	reg whi_pend_q;
	reg [ADDR_W-1:0] wcur_addr_q;
	reg [WORD_W-1:0] wlo_q;
	reg [WORD_W-1:0] whi_q;
	reg wr_go_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wq_valid_q <= 1'b0;
			wq_addr_q <= {ADDR_W{1'b0}};
			whi_pend_q <= 1'b0;
			wcur_addr_q <= {ADDR_W{1'b0}};
			wlo_q <= {WORD_W{1'b0}};
			whi_q <= {WORD_W{1'b0}};
			wr_go_q <= 1'b0;
		end else if (ce) begin
			wr_go_q <= 1'b0;
			if (kt_rise) begin
				wq_valid_q <= wr_cmd;
				wq_addr_q <= addr_s;
				if (wq_valid_q) begin
					wlo_q <= din_s;
					wcur_addr_q <= wq_addr_q;
					whi_pend_q <= 1'b1;
				end
			end
			if (kc_rise && whi_pend_q) begin
				whi_q <= din_s;
				whi_pend_q <= 1'b0;
				wr_go_q <= 1'b1;
			end
		end
	end

	// Array access: reads on the true rise, writes later on the comp rise
	reg rd_go_q;
	reg [ADDR_W-1:0] rd_addr_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_go_q <= 1'b0;
			rd_addr_q <= {ADDR_W{1'b0}};
		end else if (ce) begin
			rd_go_q <= rd_cmd;
			if (rd_cmd) begin
				rd_addr_q <= addr_s;
			end
		end
	end

	wire [2*WORD_W-1:0] arr_rdata;
	burst_sram_array #(
		.ADDR_W(ADDR_W),
		.DATA_W(2 * WORD_W)
	) u_array (
		.clk(clk),
		.ce(ce),
		.wr_en(wr_go_q),
		.rd_en(rd_go_q),
		.addr(wr_go_q ? wcur_addr_q : rd_addr_q),
		.wr_data({whi_q, wlo_q}),
		.rd_data_q(arr_rdata)
	);

	// Hold the fetched pair until the next link edge enters it in the pipe
	reg rd_hold_v_q;
	reg rd_fetch_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_fetch_q <= 1'b0;
			rd_hold_v_q <= 1'b0;
		end else if (ce) begin
			rd_fetch_q <= rd_go_q;
			if (any_rise) begin
				rd_hold_v_q <= rd_fetch_q;
			end else if (rd_fetch_q) begin
				rd_hold_v_q <= 1'b1;
			end
		end
	end

	// Half-cycle delay line, one stage per link edge
	reg [DEPTH-1:0] pv_q;
	reg [2*WORD_W-1:0] pd_q [0:DEPTH-1];
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_pipe
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					pv_q[gi] <= 1'b0;
					pd_q[gi] <= {2*WORD_W{1'b0}};
				end else if (any_rise) begin
					if (gi == 0) begin
						pv_q[gi] <= rd_hold_v_q;
						pd_q[gi] <= arr_rdata;
					end else begin
						pv_q[gi] <= pv_q[gi-1];
						pd_q[gi] <= pd_q[gi-1];
					end
				end
			end
		end
	endgenerate

	// Latency select: 2.5 cycles with bypass select high, one cycle low.
	// Stage k holds a pair that entered k+1 edges after the command edge,
	// so the low word of latency L sits in stage L-2, the high word in L-1.
	// Changing the select while a read is in flight may drop or repeat words.
	reg bypass_s1_q;
	reg bypass_s2_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bypass_s1_q <= 1'b0;
			bypass_s2_q <= 1'b0;
		end else if (ce) begin
			bypass_s1_q <= pll_bypass_select;
			bypass_s2_q <= bypass_s1_q;
		end
	end
	wire lo_hit = bypass_s2_q ? pv_q[LAT_PLL-2] : pv_q[LAT_BYP-2];
	wire hi_hit = bypass_s2_q ? pv_q[LAT_PLL-1] : pv_q[LAT_BYP-1];
	wire [2*WORD_W-1:0] lo_pair = bypass_s2_q ? pd_q[LAT_PLL-2] : pd_q[LAT_BYP-2];
	wire [2*WORD_W-1:0] hi_pair = bypass_s2_q ? pd_q[LAT_PLL-1] : pd_q[LAT_BYP-1];

	// Output registers update on each link edge; echoes track in the same cycle
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dq_out <= {WORD_W{1'b0}};
			dq_oe_n <= 1'b1;
			read_valid_flag <= 1'b0;
			echo_strobe_true <= 1'b0;
			echo_strobe_comp <= 1'b0;
		end else if (ce) begin
			echo_strobe_true <= kt_s;
			echo_strobe_comp <= kc_s;
			if (any_rise) begin
				if (lo_hit) begin
					dq_out <= lo_pair[WORD_W-1:0];
					dq_oe_n <= 1'b0;
					read_valid_flag <= 1'b1;
				end else if (hi_hit) begin
					dq_out <= hi_pair[2*WORD_W-1:WORD_W];
					dq_oe_n <= 1'b0;
					read_valid_flag <= 1'b1;
				end else begin
					dq_oe_n <= 1'b1;
					read_valid_flag <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [tb/sram_host_model.sv]
// Host side model: free-running link clocks, commands, write data, capture.
// Assumes device outputs settle about three clk cycles after a link edge.
`timescale 1ns/1ps
`default_nettype none
module sram_host_model #(parameter WORD_W = 18, parameter ADDR_W = 6) (
	output logic link_clk_true,
	output logic link_clk_comp,
	output logic load_n,
	output logic read_not_write,
	output logic [ADDR_W-1:0] addr,
	output wire [WORD_W-1:0] dq_in,
	input wire [WORD_W-1:0] dq_out,
	input wire dq_oe_n,
	input wire read_valid_flag,
	input wire echo_strobe_true
);
	logic [WORD_W-1:0] hd;
	// Released bus shows the inverse of the last word, not a stale copy
	assign dq_in = !dq_oe_n ? dq_out : hd;
	assign link_clk_comp = !link_clk_true;
	// Edges land 1 ns after a clk rise
	initial begin
		link_clk_true = 0;
		load_n = 1;
		read_not_write = 0;
		addr = '0;
		hd = '0;
		#11;
		forever #80 link_clk_true = !link_clk_true;
	end
	// Command held half a period either side of one true rise
	task cmd(input logic rd, input logic [ADDR_W-1:0] a);
		@(negedge link_clk_true);
		load_n = 0;
		read_not_write = rd;
		addr = a;
		@(posedge link_clk_true);
		@(negedge link_clk_true);
		load_n = 1;
		addr = ~a;
	endtask
	// Low word set on the true fall, later changes mid half period, all clear of the edge that samples them
	task write(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w0, w1);
		cmd(0, a);
		hd = w0;
		@(posedge link_clk_true);
		#40;
		hd = w1;
		@(posedge link_clk_comp);
		#40;
		hd = ~w1;
	endtask
	// Words sampled mid-window after each echo edge, counted from E1
	task read(input logic [ADDR_W-1:0] a, output int first, output logic [2*WORD_W-1:0] w);
		int n;
		n = 0;
		first = -1;
		w = '0;
		cmd(1, a);
		#40;
		for (int j = 1; j < 9; j++) begin
			@(echo_strobe_true);
			#40;
			if (read_valid_flag === 1'h1 && n < 2) begin
				if (n == 0) first = j;
				w[n*WORD_W +: WORD_W] = dq_out;
				n++;
			end
		end
	endtask
endmodule
`default_nettype wire

// [tb/dual_rate_burst_sram_port_asserts.sv]
// Checker on the port pins of the burst SRAM device side.
// Assumes ce high and a link half period of exactly four clk cycles.
`timescale 1ns/1ps
`default_nettype none
module burst_port_asserts #(parameter WORD_W = 18, parameter ADDR_W = 21) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire link_clk_true,
	input wire link_clk_comp,
	input wire load_n,
	input wire read_not_write,
	input wire [ADDR_W-1:0] addr,
	input wire pll_bypass_select,
	input wire [WORD_W-1:0] dq_in,
	input wire [WORD_W-1:0] dq_out,
	input wire dq_oe_n,
	input wire read_valid_flag,
	input wire echo_strobe_true,
	input wire echo_strobe_comp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	oe_valid_a: assert property (dq_oe_n == !read_valid_flag)
		else $error("drive enable and valid disagree");
	reset_quiet_a: assert property ($rose(arst_n) |-> dq_oe_n && !read_valid_flag)
		else $error("pins driven after reset");
	valid_len_a: assert property ($rose(read_valid_flag) |-> read_valid_flag[*8] ##1 !read_valid_flag)
		else $error("valid not two words long");
	word_hold_a: assert property ($rose(read_valid_flag) |=> $stable(dq_out)[*3])
		else $error("first word not held");
	valid_gap_a: assert property ($fell(read_valid_flag) |-> !read_valid_flag[*4])
		else $error("valid glitch");
	echo_true_a: assert property ($changed(echo_strobe_true) |->
		echo_strobe_true == $past(link_clk_true, 3) || echo_strobe_true == $past(link_clk_true, 4))
		else $error("echo true not following link");
	echo_anti_a: assert property ($changed(echo_strobe_true) |-> echo_strobe_comp != echo_strobe_true)
		else $error("echo pair not opposite");
	valid_echo_a: assert property ($rose(read_valid_flag) |->
		echo_strobe_true != $past(echo_strobe_true) || echo_strobe_true != $past(echo_strobe_true, 2))
		else $error("valid not aligned to echo");
endmodule
bind dual_rate_burst_sram_port burst_port_asserts #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// [tb/test_dual_rate_burst_sram_port.sv]
// Bench: host model on the link pins, checker bound into the port.
// Assumes 50 MHz clk and a 160 ns link period; ce held high.
`timescale 1ns/1ps
`default_nettype none
module test_dual_rate_burst_sram_port;
	logic clk, arst_n, byp;
	wire lt, lc, ld_n, rnw, oe_n, vld, et, ec;
	wire [5:0] a;
	wire [17:0] di, dq;
	int bad_count = 0;
	int check_count = 0;
	int first;
	logic [35:0] w;
	dual_rate_burst_sram_port #(.WORD_W(18), .ADDR_W(6)) uut (.clk(clk), .arst_n(arst_n),
		.ce(1'h1), .link_clk_true(lt), .link_clk_comp(lc), .load_n(ld_n), .read_not_write(rnw),
		.addr(a), .pll_bypass_select(byp), .dq_in(di), .dq_out(dq), .dq_oe_n(oe_n),
		.read_valid_flag(vld), .echo_strobe_true(et), .echo_strobe_comp(ec));
	sram_host_model #(.WORD_W(18), .ADDR_W(6)) host (.link_clk_true(lt), .link_clk_comp(lc),
		.load_n(ld_n), .read_not_write(rnw), .addr(a), .dq_in(di), .dq_out(dq),
		.dq_oe_n(oe_n), .read_valid_flag(vld), .echo_strobe_true(et));
	task check(input string nm, input logic [35:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Latency select is synchronised, so wait for two true link clock rises
	task set_byp(input logic v);
		@(posedge clk);
		#1 byp = v;
		repeat (2) @(posedge lt);
	endtask
	task t_short;
		set_byp(1'h0);
		host.write(6'h05, 18'h2aaaa, 18'h15555);
		host.read(6'h05, first, w);
		check("short latency", first, 36'h2);
		check("burst words", w, {18'h15555, 18'h2aaaa});
		$display("short latency test done");
	endtask
	task t_long;
		set_byp(1'h1);
		host.write(6'h3f, 18'h3ffff, 18'h00001);
		host.read(6'h3f, first, w);
		check("long latency", first, 36'h5);
		check("top address", w, 36'h00007ffff);
		host.read(6'h05, first, w);
		check("kept words", w, {18'h15555, 18'h2aaaa});
		$display("long latency test done");
	endtask
	// Clock
	initial begin
		clk = 0;
		forever #10 clk = !clk;
	end
	// Watchdog well beyond the few microseconds the tests need
	initial begin
		#60000;
		bad_count++;
		finish_test;
	end
	// Main sequence
	initial begin
		arst_n = 0;
		byp = 0;
		repeat (10) @(posedge clk);
		#1 arst_n = 1;
		check("idle drive", oe_n, 36'h1);
		t_short;
		t_long;
		finish_test;
	end
endmodule
`default_nettype wire
